// ==== hw/prs_pkg.sv ====
// Package for the pot reset sequencer: widths, defaults and types
package prs_pkg;
   localparam int          PRS_NUM_WIPERS    = 4;
   localparam int          PRS_NUM_TERMINAL_CONNECT_REGISTER      = 2;
   localparam int          PRS_TERMINAL_CONNECT_REGISTER_W        = 9;
   localparam int          PRS_RES_BITS_DEF  = 8;
   localparam int          PRS_WIPER_W_MAX   = 9;
   localparam logic [8:0]  PRS_TERMINAL_CONNECT_REGISTER_DEFAULT  = 9'h1ff;
   localparam logic [8:0]  PRS_WIPER_ZERO    = 9'h000;
   localparam logic [8:0]  PRS_FULL_8BIT     = 9'h100;
   localparam logic [8:0]  PRS_FULL_7BIT     = 9'h080;
   localparam logic [6:0]  PRS_ADDR_BASE_DEF = 7'h2c;
   localparam int          PRS_STRAP_BITS    = 2;

   typedef enum {PRS_ST_RESET, PRS_ST_LOAD, PRS_ST_RUN} prs_state_t;

   // Volatile write request from the serial engine
   typedef struct packed {
      logic       wr_en;
      logic       inc_en;
      logic       dec_en;
      logic       is_terminal_connect_register;
      logic [1:0] index;
      logic [8:0] data;
   } prs_req_t;

   // Open-drain data pin bundle
   typedef struct packed {
      logic out;
      logic oe_n;
   } prs_od_t;
endpackage

// ==== hw/prs_reset_sync.sv ====
// Combines power-on detector and reset pin into one internal reset
`timescale 1ns/1ps
module prs_reset_sync
   import prs_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic por_bor_active_i,
   input  wire logic reset_pin_n_i,
   output logic      hold_reset_o,
   output logic      load_pulse_o
);
   logic hold_reg;
   logic hold_d_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_reg <= 1'b1;
      end else begin
         hold_reg <= por_bor_active_i | ~reset_pin_n_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_d_reg <= 1'b1;
      end else begin
         hold_d_reg <= hold_reg;
      end
   end

   // Reset is forced immediately from the pins; release waits one edge
   assign hold_reset_o = hold_reg | por_bor_active_i | ~reset_pin_n_i;
   assign load_pulse_o = hold_d_reg & ~hold_reg;
endmodule

// ==== hw/prs_top.sv ====
// Reset and power-state control of a quad volatile digital pot
`timescale 1ns/1ps
module prs_top
   import prs_pkg::*;
#(
   parameter int          RES_BITS  = PRS_RES_BITS_DEF,
   parameter logic [6:0]  ADDR_BASE = PRS_ADDR_BASE_DEF
)(
   input  wire logic                       clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       por_bor_active_i,
   input  wire logic                       reset_pin_n_i,
   input  wire logic                       high_voltage_cmd_address_pin_i,
   input  wire logic                       address_strap_bit1_i,
   input  wire logic                       low_voltage_i,
   input  wire logic                       scl_i,
   input  wire logic                       sda_i,
   input  wire prs_req_t                   req_i,
   output prs_od_t                         sda_o,
   output logic                            serial_enable_o,
   output logic                            weak_pullup_en_o,
   output logic [6:0]                      slave_addr_o,
   output logic [PRS_NUM_WIPERS*9-1:0]     wiper_o,
   output logic [PRS_NUM_TERMINAL_CONNECT_REGISTER*PRS_TERMINAL_CONNECT_REGISTER_W-1:0] terminal_connect_register_o,
   output logic                            scl_seen_o
);
   localparam logic [8:0] FULL_SCALE =
      (RES_BITS == 7) ? PRS_FULL_7BIT : PRS_FULL_8BIT;
   localparam logic [8:0] MID_SCALE  = {1'b0, FULL_SCALE[8:1]};
   localparam logic [8:0] ZERO_SCALE = PRS_WIPER_ZERO;

   ////////////////////////////////////////////////////////////////////////
   // Reset state combining
   logic hold_reset;
   logic load_pulse;

   prs_reset_sync u_rst (
      .clk_i            (clk_i),
      .sys_rst_i        (sys_rst_i),
      .por_bor_active_i (por_bor_active_i),
      .reset_pin_n_i    (reset_pin_n_i),
      .hold_reset_o     (hold_reset),
      .load_pulse_o     (load_pulse)
   );

   prs_state_t state_reg;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= PRS_ST_RESET;
      end else begin
         case (state_reg)
            PRS_ST_RESET: begin
               if (load_pulse) begin
                  state_reg <= PRS_ST_LOAD;
               end
            end
            PRS_ST_LOAD: begin
               state_reg <= hold_reset ? PRS_ST_RESET : PRS_ST_RUN;
            end
            PRS_ST_RUN: begin
               if (hold_reset) begin
                  state_reg <= PRS_ST_RESET;
               end
            end
            default: state_reg <= PRS_ST_RESET;
         endcase
      end
   end

   logic running;
   // Low supply is deliberately not gated: volatile commands still run
   assign running         = (state_reg == PRS_ST_RUN) & ~hold_reset;
   assign serial_enable_o = running;
   assign weak_pullup_en_o = por_bor_active_i | ~reset_pin_n_i;

   ////////////////////////////////////////////////////////////////////////
   // Address strap capture
   logic addr0_reg;
   logic addr1_reg;

   // A0 shares the high-voltage pin, so it is only sampled while the power-on/brown-out detector is active, not on the reset pin
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr0_reg <= 1'b0;
      end else if (por_bor_active_i) begin
         addr0_reg <= high_voltage_cmd_address_pin_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr1_reg <= 1'b0;
      end else begin
         addr1_reg <= address_strap_bit1_i;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         slave_addr_o <= ADDR_BASE;
      end else begin
         slave_addr_o <= {ADDR_BASE[6:PRS_STRAP_BITS],
                          addr1_reg, addr0_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Volatile wiper registers
   logic [8:0] wiper_reg [PRS_NUM_WIPERS];
   logic       req_ok;
   assign req_ok = running & ~req_i.is_terminal_connect_register;

   function automatic logic [8:0] clip(input logic [8:0] v);
      clip = (v > FULL_SCALE) ? FULL_SCALE : v;
   endfunction

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < PRS_NUM_WIPERS; i++) begin
            wiper_reg[i] <= MID_SCALE;
         end
      end else if (hold_reset || state_reg == PRS_ST_LOAD) begin
         for (int i = 0; i < PRS_NUM_WIPERS; i++) begin
            wiper_reg[i] <= MID_SCALE;
         end
      end else if (req_ok) begin
         if (req_i.wr_en) begin
            wiper_reg[req_i.index] <= clip(req_i.data);
         end else if (req_i.inc_en &&
                      wiper_reg[req_i.index] != FULL_SCALE) begin
            wiper_reg[req_i.index] <= wiper_reg[req_i.index] + 9'h001;
         end else if (req_i.dec_en &&
                      wiper_reg[req_i.index] != ZERO_SCALE) begin
            wiper_reg[req_i.index] <= wiper_reg[req_i.index] - 9'h001;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wiper_o <= {PRS_NUM_WIPERS{MID_SCALE}};
      end else begin
         for (int i = 0; i < PRS_NUM_WIPERS; i++) begin
            wiper_o[i*9 +: 9] <= wiper_reg[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Terminal connect registers
   logic [PRS_TERMINAL_CONNECT_REGISTER_W-1:0] terminal_connect_register_reg [PRS_NUM_TERMINAL_CONNECT_REGISTER];

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < PRS_NUM_TERMINAL_CONNECT_REGISTER; i++) begin
            terminal_connect_register_reg[i] <= PRS_TERMINAL_CONNECT_REGISTER_DEFAULT;
         end
      end else if (hold_reset || state_reg == PRS_ST_LOAD) begin
         for (int i = 0; i < PRS_NUM_TERMINAL_CONNECT_REGISTER; i++) begin
            terminal_connect_register_reg[i] <= PRS_TERMINAL_CONNECT_REGISTER_DEFAULT;
         end
      end else if (running && req_i.is_terminal_connect_register && req_i.wr_en) begin
         // Top bit is reserved and always reads one
         terminal_connect_register_reg[req_i.index[0]] <= {1'b1, req_i.data[7:0]};
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         terminal_connect_register_o <= {PRS_NUM_TERMINAL_CONNECT_REGISTER{PRS_TERMINAL_CONNECT_REGISTER_DEFAULT}};
      end else begin
         for (int i = 0; i < PRS_NUM_TERMINAL_CONNECT_REGISTER; i++) begin
            terminal_connect_register_o[i*PRS_TERMINAL_CONNECT_REGISTER_W +: PRS_TERMINAL_CONNECT_REGISTER_W] <=
               terminal_connect_register_reg[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial pins: clock is input only, data is open drain
   // The clock pin has no output at all; the host makes every edge
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_seen_o <= 1'b0;
      end else begin
         scl_seen_o <= running & scl_i;
      end
   end

   // Acknowledge pull-down while running; bus is left alone in reset
   logic ack_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= running & ~scl_i & sda_i &
                    (req_i.wr_en | req_i.inc_en | req_i.dec_en);
      end
   end

   assign sda_o.out  = 1'b0;
   assign sda_o.oe_n = ~ack_reg;
endmodule

// ==== tb/prs_top_properties.sv ====
// Checker: reset defaults, pin behaviour and wiper writes
`timescale 1ns/1ps
module prs_top_properties
   import prs_pkg::*;
#(
   parameter int         RES_BITS  = PRS_RES_BITS_DEF,
   parameter logic [6:0] ADDR_BASE = PRS_ADDR_BASE_DEF
)(
   input wire logic        clk_i,
   input wire logic        sys_rst_i,
   input wire logic        por_bor_active_i,
   input wire logic        reset_pin_n_i,
   input wire logic        address_strap_bit1_i,
   input wire prs_req_t    req_i,
   input wire prs_od_t     sda_o,
   input wire logic        serial_enable_o,
   input wire logic        weak_pullup_en_o,
   input wire logic [6:0]  slave_addr_o,
   input wire logic [35:0] wiper_o,
   input wire logic [17:0] terminal_connect_register_o
);
   localparam logic [8:0] MID  = 9'h001 << (RES_BITS - 1);
   localparam logic [8:0] FULL = 9'h001 << RES_BITS;
   logic pin_rst;
   assign pin_rst = por_bor_active_i | ~reset_pin_n_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_sda_low_only: assert property (sda_o.out == 1'b0)
      else $error("data pin driven high");
   a_pullup_pins: assert property (weak_pullup_en_o == pin_rst)
      else $error("pull-up enable wrong");
   a_serial_off: assert property (pin_rst |-> !serial_enable_o)
      else $error("serial port on during reset");
   a_wiper_mid: assert property (pin_rst [*3] |=> wiper_o == {4{MID}})
      else $error("wiper not mid-scale in reset");
   a_terminal_connect_register_def: assert property (pin_rst [*3] |=>
      terminal_connect_register_o == {2{PRS_TERMINAL_CONNECT_REGISTER_DEFAULT}})
      else $error("terminal register not default in reset");
   a_addr_strap: assert property (serial_enable_o && $past(serial_enable_o)
      && $stable(address_strap_bit1_i) |->
      slave_addr_o[6:1] == {ADDR_BASE[6:2], address_strap_bit1_i})
      else $error("slave address strap bits wrong");
   a_addr_kept: assert property (serial_enable_o && $past(serial_enable_o)
      |-> $stable(slave_addr_o[0]))
      else $error("address bit 0 changed while running");
   a_wiper_write: assert property (
      serial_enable_o && req_i.wr_en && !req_i.is_terminal_connect_register |-> ##2
      wiper_o[$past(req_i.index, 2)*9 +: 9] ==
      ($past(req_i.data, 2) > FULL ? FULL : $past(req_i.data, 2)))
      else $error("wiper write value wrong");
   c_pin_release: cover property (pin_rst ##1 !pin_rst);
   c_inc: cover property (serial_enable_o && req_i.inc_en);
   c_dec: cover property (serial_enable_o && req_i.dec_en);
endmodule
bind prs_top prs_top_properties
   #(.RES_BITS(RES_BITS), .ADDR_BASE(ADDR_BASE)) u_props (.*);

// ==== tb/prs_host_model.sv ====
// Bus host model: drives clock and data frames onto the serial pins
`timescale 1ns/1ps
module prs_host_model
   import prs_pkg::*;
(
   input  wire logic    clk_i,
   input  wire logic    go_i,
   input  wire prs_od_t dev_i,
   output logic         scl_o,
   output logic         sda_o
);
   logic [3:0] cnt_reg = 4'h0;
   always_ff @(posedge clk_i) begin
      if (go_i) begin
         cnt_reg <= 4'h8;
      end else if (cnt_reg != 4'h0) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
   // Clock stands high between frames
   assign scl_o = (cnt_reg == 4'h0) | cnt_reg[0];
   // Pull-up wins unless either party pulls low
   assign sda_o = dev_i.oe_n & (cnt_reg != 4'h7);
endmodule

// ==== tb/prs_top_tb.sv ====
// Self-checking bench for the pot reset sequencer
`timescale 1ns/1ps
module prs_top_tb;
   import prs_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, por_bor_active_i = 1, reset_pin_n_i = 1;
   logic strap0 = 1, strap1 = 1, low_v = 0, go = 0, scl, sda;
   prs_req_t req_i = '0;
   prs_od_t sda_o;
   logic en, pull, seen;
   logic [6:0] addr;
   logic [35:0] wiper_o;
   logic [17:0] terminal_connect_register;
   int err_count = 0, cmp_count = 0, cyc = 0;
   always #25 clk_i = ~clk_i;
   prs_host_model host (.clk_i, .go_i(go), .dev_i(sda_o), .scl_o(scl),
      .sda_o(sda));
   prs_top dut (.clk_i, .sys_rst_i, .por_bor_active_i, .reset_pin_n_i,
      .high_voltage_cmd_address_pin_i(strap0), .address_strap_bit1_i(strap1),
      .low_voltage_i(low_v), .scl_i(scl), .sda_i(sda), .req_i, .sda_o,
      .serial_enable_o(en), .weak_pullup_en_o(pull), .slave_addr_o(addr),
      .wiper_o, .terminal_connect_register_o(terminal_connect_register), .scl_seen_o(seen));
   task automatic cmp(input string n, input logic [8:0] e, s);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Op bits: write, increment, decrement, terminal register
   task automatic send(input logic [3:0] op, input logic [1:0] ix,
                       input logic [8:0] d);
      @(negedge clk_i);
      req_i = {op, ix, d};
      @(negedge clk_i);
      req_i = '0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic wait_run();
      for (int i = 0; i < 20 && en !== 1'b1; i++) @(negedge clk_i);
      @(negedge clk_i);
      cmp("enable", 9'h001, {8'h00, en});
   endtask
   function automatic logic [8:0] wp(input int i);
      return wiper_o[i*9 +: 9];
   endfunction
   task automatic t_defaults();
      wait_run();
      for (int i = 0; i < 4; i++) cmp("wiper", 9'h080, wp(i));
      cmp("terminal_connect_register", 9'h1ff, terminal_connect_register[8:0]);
      cmp("addr", {2'h0, PRS_ADDR_BASE_DEF[6:2], 2'b11}, {2'h0, addr});
      cmp("pullup", 9'h000, {8'h00, pull});
      $display("test defaults done");
   endtask
   task automatic t_cmds();
      low_v = 1;
      go = 1;
      @(negedge clk_i);
      go = 0;
      send(4'h8, 2'd1, 9'h000);
      cmp("zero", 9'h000, wp(1));
      send(4'h8, 2'd2, 9'h1ff);
      cmp("clip", 9'h100, wp(2));
      send(4'h4, 2'd2, 9'h000);
      cmp("inc full", 9'h100, wp(2));
      send(4'h2, 2'd1, 9'h000);
      cmp("dec zero", 9'h000, wp(1));
      send(4'h4, 2'd3, 9'h000);
      cmp("inc", 9'h081, wp(3));
      send(4'h9, 2'd1, 9'h0a5);
      cmp("terminal_connect_register wr", 9'h1a5, terminal_connect_register[17:9]);
      cmp("scl seen", 9'h001, {8'h00, seen});
      $display("test commands done");
   endtask
   task automatic t_pin_reset();
      @(negedge clk_i);
      reset_pin_n_i = 0;
      #1;
      cmp("en off", 9'h000, {8'h00, en});
      cmp("pullup on", 9'h001, {8'h00, pull});
      send(4'h8, 2'd0, 9'h033);
      cmp("refused", 9'h080, wp(0));
      cmp("reload", 9'h080, wp(2));
      cmp("terminal_connect_register def", 9'h1ff, terminal_connect_register[17:9]);
      cmp("scl gated", 9'h000, {8'h00, seen});
      cmp("sda released", 9'h001, {8'h00, sda_o.oe_n});
      reset_pin_n_i = 1;
      wait_run();
      $display("test reset pin done");
   endtask
   task automatic t_brownout();
      send(4'h8, 2'd3, 9'h055);
      strap0 = 0;
      por_bor_active_i = 1;
      #1;
      cmp("bor off", 9'h000, {8'h00, en});
      repeat (4) @(negedge clk_i);
      por_bor_active_i = 0;
      strap0 = 1;
      wait_run();
      cmp("bor wiper", 9'h080, wp(3));
      cmp("a0 kept", 9'h000, {8'h00, addr[0]});
      $display("test brown-out done");
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      sys_rst_i = 0;
      // Power-on detector stays up briefly so the address pin is captured
      repeat (2) @(negedge clk_i);
      por_bor_active_i = 0;
      t_defaults();
      t_cmds();
      t_pin_reset();
      t_brownout();
      tally_and_finish();
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         tally_and_finish();
      end
   end
endmodule
